// >>> bench/lpc_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module lpc_link_assertions
	import lpc_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic lclk,
	input wire logic lframe_n,
	input wire logic [3:0] lad_host,
	input wire logic lad_host_oe,
	input wire logic [3:0] lad_dev,
	input wire logic lad_dev_oe,
	input wire logic a20_pin,
	input wire logic a20_pin_oe
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	logic [7:0] drive_cnt_q;
	logic [7:0] drive_cnt_d;
	// Longest device turn is a read: sync, two data nibbles, recovery
	always_comb begin
		drive_cnt_d = lad_dev_oe ? drive_cnt_q + 8'h01 : 8'h00;
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			drive_cnt_q <= 8'h00;
		end else begin
			drive_cnt_q <= drive_cnt_d;
		end
	end
	AST_NO_CONTENTION: assert property (!(lad_host_oe && lad_dev_oe))
		else $error("both ends drive the data lines");
	AST_SYNC_READY: assert property ($rose(lad_dev_oe) |-> lad_dev == LAD_SYNC_READY && !lad_host_oe)
		else $error("device turn does not open with the ready code");
	AST_RESET_IDLE: assert property ($past(rst_in) |-> lframe_n && !lad_host_oe && !lad_dev_oe)
		else $error("link not idle after reset");
	AST_A20_RESET: assert property ($past(rst_in) |-> a20_pin == A20_RESET_VALUE)
		else $error("mask pin not one after reset");
	AST_FRAME_BY_HOST: assert property (!lframe_n |-> lad_host_oe)
		else $error("frame low without host driving");
	AST_HOST_ON_FALL: assert property ($changed(lad_host) && lad_host_oe |-> !lclk)
		else $error("host nibble changed outside link clock low");
	AST_DEV_RELEASE_F: assert property ($fell(lad_dev_oe) |-> $past(lad_dev) == LAD_RECOVERY)
		else $error("device released without recovery nibble");
	AST_DEV_TURN_BOUNDED: assert property (drive_cnt_q < 8'h29)
		else $error("device drives too long");
	AST_DEV_QUIET_IN_FRAME: assert property (!lframe_n |-> !lad_dev_oe)
		else $error("device drives during a frame or abort");
endmodule : lpc_link_assertions
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import lpc_pkg::*;
	logic clk_sys_in, rst_in, hwr_s, hrd_s, fa20, pme, smi, sci, fw_we, fw_val, rdi, wro, cd1, abort_flag, busy, pact, a20;
	logic [3:0] haddr, chan_en, input_buffer_full, xpins;
	logic [15:0] hwdata, hrdata, a1, a2, a3, a4, s;
	logic [1:0] rch, wch;
	logic [7:0] odata, input_data_reg, q;
	logic drove, seen_busy;
	int n_fail, n_compared;
	// {command, byte, expected buffer-full, expected mask}
	logic [10:0] tbl [10] = '{{1'b1, 8'hD1, 2'b01}, {1'b0, 8'h00, 2'b00}, {1'b1, 8'hFF, 2'b00},
		{1'b1, 8'hD1, 2'b00}, {1'b1, 8'hD1, 2'b00}, {1'b0, 8'h02, 2'b01}, {1'b1, 8'hD1, 2'b01},
		{1'b1, 8'h20, 2'b11}, {1'b0, 8'h00, 2'b11}, {1'b1, 8'hD1, 2'b01}};
	lpc_if bus();
	lpc_host u_lpc_host(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .lpc(bus), .addr_in(haddr), .wdata_in(hwdata),
		.wr_in(hwr_s), .rd_in(hrd_s), .rdata_out(hrdata));
	lpc_dev u_lpc_dev(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .lpc(bus), .chan_enable_in(chan_en),
		.fast_a20_enable_in(fa20), .power_event_pin_enable_in(pme), .smi_pin_enable_in(smi),
		.sci_pin_enable_in(sci), .chan1_host_address_in(a1), .chan2_host_address_in(a2),
		.chan3_host_address_in(a3), .chan4_host_address_in(a4), .fw_a20_we_in(fw_we), .fw_a20_value_in(fw_val),
		.rd_chan_in(rch), .rd_input_in(rdi), .wr_chan_in(wch), .wr_output_in(wro), .output_data_in(odata),
		.input_data_reg_out(input_data_reg), .input_buffer_full_out(input_buffer_full), .chan1_cmd_or_data_flag_out(cd1),
		.abort_flag_out(abort_flag), .busy_out(busy), .port_active_out(pact), .extra_pins_active_out(xpins),
		.addr_line20_mask_out(a20));
	lpc_link_assertions u_lpc_link_assertions(.clk_sys_in(clk_sys_in), .rst_in(rst_in), .lclk(bus.lclk),
		.lframe_n(bus.lframe_n), .lad_host(bus.lad_host), .lad_host_oe(bus.lad_host_oe), .lad_dev(bus.lad_dev),
		.lad_dev_oe(bus.lad_dev_oe), .a20_pin(bus.a20_pin), .a20_pin_oe(bus.a20_pin_oe));
	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		if (bus.lad_dev_oe) begin
			drove = 1'b1;
		end
		if (busy) begin
			seen_busy = 1'b1;
		end
	end
	task automatic wrap_up();
		$display("Compared %0d, failures %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic hw(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys_in);
		haddr <= a;
		hwdata <= d;
		hwr_s <= 1'b1;
		@(posedge clk_sys_in);
		hwr_s <= 1'b0;
	endtask : hw
	task automatic hr(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys_in);
		haddr <= a;
		hrd_s <= 1'b1;
		@(posedge clk_sys_in);
		hrd_s <= 1'b0;
		#1 d = hrdata;
	endtask : hr
	task automatic go(input logic wr, input logic [15:0] a, input logic [7:0] d);
		hw(HREG_ADDR, a);
		hw(HREG_WDATA, {8'h00, d});
		hw(HREG_CTRL, {14'h0000, wr, 1'b1});
	endtask : go
	task automatic fin(output logic [7:0] r);
		int i;
		s = 16'h0003;
		for (i = 0; i < 200 && s[1:0] !== 2'b00; i++) begin
			hr(HREG_STATUS, s);
		end
		chk(s[1:0], 2'b00);
		hr(HREG_RDATA, s);
		r = s[7:0];
	endtask : fin
	task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r);
		go(wr, a, d);
		fin(r);
		// Host drops busy before the device's recovery nibble commits
		repeat (8) @(posedge clk_sys_in);
	endtask : io
	task automatic drd(input logic [1:0] c, output logic [7:0] d);
		@(posedge clk_sys_in);
		rch <= c;
		rdi <= 1'b1;
		@(posedge clk_sys_in);
		rdi <= 1'b0;
		#1 d = input_data_reg;
	endtask : drd
	initial begin
		#(40 * 40000);
		n_fail++;
		wrap_up();
	end
	initial begin
		{hwr_s, hrd_s, fa20, pme, smi, sci, fw_we, fw_val, rdi, wro, haddr, chan_en, hwdata, rch, wch, odata} = '0;
		n_fail = 0;
		n_compared = 0;
		drove = 1'b0;
		seen_busy = 1'b0;
		// Addresses are settled before any channel is enabled
		a1 = CHAN1_ADDR_RESET;
		a2 = 16'h0200;
		a3 = CHAN3_ADDR_RESET;
		a4 = CHAN4_ADDR_RESET;
		rst_in = 1'b1;
		repeat (4) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		#1 chk(a20, 1'b1);
		chk(pact, 1'b0);
		@(posedge clk_sys_in);
		chan_en <= 4'h3;
		{fa20, pme, smi, sci} <= 4'hF;
		repeat (3) @(posedge clk_sys_in);
		#1 chk(pact, 1'b1);
		chk(xpins, 4'hF);
		chk({bus.a20_pin_oe, bus.a20_pin}, 2'b11);
		io(1'b1, a1, 8'h5A, q);
		chk({input_buffer_full, cd1}, 5'h02);
		drd(2'h0, q);
		chk({q, input_buffer_full}, 12'h5A0);
		@(posedge clk_sys_in);
		odata <= 8'hC3;
		wro <= 1'b1;
		@(posedge clk_sys_in);
		wro <= 1'b0;
		io(1'b0, a1, 8'h00, q);
		chk(q, 8'hC3);
		for (int k = 0; k < 10; k++) begin
			io(1'b1, tbl[k][10] ? (a1 | CMD_PORT_OFFSET) : a1, tbl[k][9:2], q);
			chk({input_buffer_full[0], a20, bus.a20_pin, cd1}, {tbl[k][1], tbl[k][0], tbl[k][0], tbl[k][10]});
			if (tbl[k][1]) begin
				drd(2'h0, q);
			end
		end
		io(1'b1, a1, 8'hFD, q);
		chk({input_buffer_full[0], a20}, 2'b00);
		io(1'b0, a1 | CMD_PORT_OFFSET, 8'h00, q);
		chk(q[2], 1'b0);
		io(1'b1, a2, 8'h33, q);
		chk(input_buffer_full, 4'h2);
		drd(2'h1, q);
		chk({q, input_buffer_full}, 12'h330);
		drove = 1'b0;
		io(1'b1, 16'h0300, 8'h11, q);
		io(1'b0, 16'h0301, 8'h00, q);
		chk({drove, input_buffer_full}, 5'h00);
		go(1'b1, a1, 8'h77);
		repeat (24) @(posedge clk_sys_in);
		hw(HREG_CTRL, 16'h0004);
		fin(q);
		chk({abort_flag, busy, input_buffer_full}, 6'h20);
		@(posedge clk_sys_in);
		fa20 <= 1'b0;
		fw_val <= 1'b1;
		fw_we <= 1'b1;
		@(posedge clk_sys_in);
		fw_we <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1 chk({a20, bus.a20_pin_oe}, 2'b10);
		io(1'b0, a1 | CMD_PORT_OFFSET, 8'h00, q);
		chk(q[3:0], 4'h4);
		chk(seen_busy, 1'b1);
		wrap_up();
	end
endmodule : tb
`default_nettype wire

// >>> common/lpc_if.sv
`timescale 1ns/100ps
`default_nettype none
interface lpc_if;
	logic lclk;
	logic lframe_n;
	logic [3:0] lad_host;
	logic lad_host_oe;
	logic [3:0] lad_dev;
	logic lad_dev_oe;
	logic a20_pin;
	logic a20_pin_oe;
	wire [3:0] lad = lad_host_oe ? lad_host : (lad_dev_oe ? lad_dev : 4'hF);
	modport host (output lclk, output lframe_n, output lad_host, output lad_host_oe, input lad);
	modport device (input lclk, input lframe_n, output lad_dev, output lad_dev_oe, input lad,
		output a20_pin, output a20_pin_oe);
endinterface : lpc_if
`default_nettype wire

// >>> common/lpc_pkg.sv
package lpc_pkg;
	localparam logic [3:0] LAD_START = 4'h0;
	localparam logic [3:0] LAD_TYPE_IO_RD = 4'h0;
	localparam logic [3:0] LAD_TYPE_IO_WR = 4'h2;
	localparam logic [3:0] LAD_SYNC_READY = 4'h0;
	localparam logic [3:0] LAD_RECOVERY = 4'hF;
	localparam logic [7:0] CMD_A20_WRITE = 8'hD1;
	localparam logic [7:0] CMD_A20_NULL = 8'hFF;
	localparam int A20_DATA_BIT = 1;
	localparam logic A20_RESET_VALUE = 1'b1;
	localparam int CLK_DIV_HALF = 4;
	localparam int SYNC_TIMEOUT = 4;
	// Device registers, reached by host I/O cycles
	localparam logic [15:0] CHAN1_ADDR_RESET = 16'h0060;
	localparam logic [15:0] CHAN2_ADDR_RESET = 16'h0068;
	localparam logic [15:0] CHAN3_ADDR_RESET = 16'h0070;
	localparam logic [15:0] CHAN4_ADDR_RESET = 16'h0078;
	localparam logic [15:0] CMD_PORT_OFFSET = 16'h0004;
	// Host controller local registers
	localparam logic [3:0] HREG_ADDR = 4'h0;
	localparam logic [3:0] HREG_WDATA = 4'h1;
	localparam logic [3:0] HREG_CTRL = 4'h2;
	localparam logic [3:0] HREG_STATUS = 4'h3;
	localparam logic [3:0] HREG_RDATA = 4'h4;
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_WRITE_BIT = 1;
	localparam int CTRL_ABORT_BIT = 2;
endpackage : lpc_pkg

// >>> logic/lpc_dev.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// [R01] Any channel enable activates port pins
// [R02] Extra function enables add their pins
// [R03] Software sets addresses before enabling
// [R04] Reading input data clears buffer-full
// [R05] Only I/O read and write supported
// [R06] Start tracked on LFRAME low idle
// [R07] LFRAME low mid-cycle aborts transfer
// [R08] Fields move as nibbles per LCLK
// [R09] Sync always returns ready code
// [R10] Address match busy until count twelve
// [R11] Updates only at closing turnaround
// [R12] Read cycle field order fixed
// [R13] Write cycle field order fixed
// [R14] Fast A20 enable drives mask pin
// [R15] A20 state resets to one
// [R16] A20 state readable by software
// [R17] D1 then data bit1 sets A20
// [R18] D1 sequence and FF skip buffer-full
// [R19] Other command cancels pending D1
// [R20] Repeated D1 retriggers the sequence
// [R21] Firmware copies A20 when fast off
// [R22] Unclaimed cycles never drive LAD
module lpc_dev (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	lpc_if.device lpc,
	input wire logic [3:0] chan_enable_in,
	input wire logic fast_a20_enable_in,
	input wire logic power_event_pin_enable_in,
	input wire logic smi_pin_enable_in,
	input wire logic sci_pin_enable_in,
	input wire logic [15:0] chan1_host_address_in,
	input wire logic [15:0] chan2_host_address_in,
	input wire logic [15:0] chan3_host_address_in,
	input wire logic [15:0] chan4_host_address_in,
	input wire logic fw_a20_we_in,
	input wire logic fw_a20_value_in,
	input wire logic [1:0] rd_chan_in,
	input wire logic rd_input_in,
	input wire logic [1:0] wr_chan_in,
	input wire logic wr_output_in,
	input wire logic [7:0] output_data_in,
	output logic [7:0] input_data_reg_out,
	output logic [3:0] input_buffer_full_out,
	output logic chan1_cmd_or_data_flag_out,
	output logic abort_flag_out,
	output logic busy_out,
	output logic port_active_out,
	output logic [3:0] extra_pins_active_out,
	output logic addr_line20_mask_out
);
	import lpc_pkg::*;
	typedef enum {S_IDLE, S_TYPE, S_ADDR, S_WDATA, S_TAR1, S_TAR2, S_SYNC, S_RDATA, S_RECOV, S_IGNORE} st_t;
	logic [2:0] clk_sync_q, frm_sync_q;
	logic [3:0] lad_s1_q, lad_s2_q;
	logic lclk_rise;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			clk_sync_q <= 3'h0;
			frm_sync_q <= 3'h7;
			lad_s1_q <= 4'hF;
			lad_s2_q <= 4'hF;
		end else begin
			clk_sync_q <= {clk_sync_q[1:0], lpc.lclk};
			frm_sync_q <= {frm_sync_q[1:0], lpc.lframe_n};
			lad_s1_q <= lpc.lad;
			lad_s2_q <= lad_s1_q;
		end
	end
	// Bit 0 is the first stage; bits 1 and 2 feed the edge detect
	assign lclk_rise = clk_sync_q[1] & ~clk_sync_q[2];
	st_t st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic wr_q, wr_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0] data_q, data_d;
	logic [1:0] ch_q, ch_d;
	logic cmd_q, cmd_d;
	logic [3:0] lad_o_q, lad_o_d;
	logic lad_oe_q, lad_oe_d;
	logic [7:0] idr_q [4];
	logic [7:0] idr_d [4];
	logic [7:0] odr_q [4];
	logic [7:0] odr_d [4];
	logic [3:0] ibf_q, ibf_d, obf_q, obf_d;
	logic cd1_q, cd1_d, a20_q, a20_d, d1_pend_q, d1_pend_d, abort_q, abort_d;
	logic [7:0] rdo_q, rdo_d;
	logic hit;
	logic [1:0] hit_ch;
	logic hit_cmd;
	logic [15:0] full_addr;
	always_comb begin
		full_addr = {addr_q[11:0], lad_s2_q};
		hit = 1'b0;
		hit_ch = 2'd0;
		hit_cmd = 1'b0;
		if (chan_enable_in[0] && (full_addr & ~CMD_PORT_OFFSET) == chan1_host_address_in) begin // [R10]
			hit = 1'b1;
			hit_ch = 2'd0;
		end else if (chan_enable_in[1] && (full_addr & ~CMD_PORT_OFFSET) == chan2_host_address_in) begin
			hit = 1'b1;
			hit_ch = 2'd1;
		end else if (chan_enable_in[2] && (full_addr & ~CMD_PORT_OFFSET) == chan3_host_address_in) begin
			hit = 1'b1;
			hit_ch = 2'd2;
		end else if (chan_enable_in[3] && (full_addr & ~CMD_PORT_OFFSET) == chan4_host_address_in) begin
			hit = 1'b1;
			hit_ch = 2'd3;
		end
		hit_cmd = |(full_addr & CMD_PORT_OFFSET);
	end
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		addr_d = addr_q;
		data_d = data_q;
		ch_d = ch_q;
		cmd_d = cmd_q;
		lad_o_d = lad_o_q;
		lad_oe_d = lad_oe_q;
		idr_d = idr_q;
		odr_d = odr_q;
		ibf_d = ibf_q;
		obf_d = obf_q;
		cd1_d = cd1_q;
		a20_d = a20_q;
		d1_pend_d = d1_pend_q;
		abort_d = abort_q;
		rdo_d = rdo_q;
		if (wr_output_in) begin
			odr_d[wr_chan_in] = output_data_in;
			obf_d[wr_chan_in] = 1'b1;
		end
		if (rd_input_in) begin
			rdo_d = idr_q[rd_chan_in];
			ibf_d[rd_chan_in] = 1'b0; // [R04]
		end
		if (fw_a20_we_in && !fast_a20_enable_in)
			a20_d = fw_a20_value_in; // [R21]
		if (lclk_rise) begin
			if (!frm_sync_q[1] && st_q != S_IDLE && st_q != S_IGNORE) begin
				// Abort: drop everything, nothing committed
				st_d = S_IDLE; // [R07] [R11]
				lad_oe_d = 1'b0;
				abort_d = 1'b1;
			end
			case (st_q)
				S_IDLE, S_IGNORE: begin
					lad_oe_d = 1'b0;
					if (!frm_sync_q[1] && lad_s2_q == LAD_START)
						st_d = S_TYPE; // [R06]
				end
				S_TYPE: if (frm_sync_q[1]) begin
					cnt_d = 3'd0;
					if (lad_s2_q == LAD_TYPE_IO_RD) begin // [R05]
						wr_d = 1'b0;
						st_d = S_ADDR;
					end else if (lad_s2_q == LAD_TYPE_IO_WR) begin
						wr_d = 1'b1;
						st_d = S_ADDR;
					end else
						st_d = S_IGNORE; // [R22]
				end else if (lad_s2_q != LAD_START)
					st_d = S_IGNORE;
				S_ADDR: if (frm_sync_q[1]) begin
					addr_d = full_addr; // [R08]
					cnt_d = cnt_q + 3'd1;
					if (cnt_q == 3'd3) begin
						cnt_d = 3'd0;
						ch_d = hit_ch;
						cmd_d = hit_cmd;
						st_d = !hit ? S_IGNORE : (wr_q ? S_WDATA : S_TAR1); // [R22]
					end
				end
				S_WDATA: if (frm_sync_q[1]) begin
					data_d = {lad_s2_q, data_q[7:4]}; // [R13]
					cnt_d = cnt_q + 3'd1;
					if (cnt_q == 3'd1)
						st_d = S_TAR1;
				end
				S_TAR1: if (frm_sync_q[1])
					st_d = S_TAR2;
				S_TAR2: if (frm_sync_q[1]) begin
					st_d = S_SYNC;
					lad_o_d = LAD_SYNC_READY; // [R09]
					lad_oe_d = 1'b1;
				end
				S_SYNC: if (frm_sync_q[1]) begin
					cnt_d = 3'd0;
					if (wr_q) begin
						st_d = S_RECOV;
						lad_o_d = LAD_RECOVERY;
					end else begin
						st_d = S_RDATA;
						lad_o_d = ch_q == 2'd0 && cmd_q ? {1'b0, a20_q, cd1_q, ibf_q[0]}
							: (cmd_q ? {2'b00, ibf_q[ch_q], obf_q[ch_q]} : odr_q[ch_q][3:0]); // [R12]
					end
				end
				S_RDATA: if (frm_sync_q[1]) begin
					cnt_d = cnt_q + 3'd1;
					if (cnt_q == 3'd0)
						lad_o_d = cmd_q ? 4'h0 : odr_q[ch_q][7:4];
					else begin
						st_d = S_RECOV;
						lad_o_d = LAD_RECOVERY;
					end
				end
				S_RECOV: if (frm_sync_q[1]) begin
					// Closing turnaround: the only commit point
					st_d = S_IDLE; // [R10] [R11]
					lad_oe_d = 1'b0;
					if (!wr_q) begin
						// New local data in the same cycle keeps the flag set
						if (!cmd_q && !(wr_output_in && wr_chan_in == ch_q))
							obf_d[ch_q] = 1'b0;
					end else if (ch_q == 2'd0 && fast_a20_enable_in) begin
						cd1_d = cmd_q;
						if (cmd_q && data_q == CMD_A20_WRITE)
							d1_pend_d = 1'b1; // [R17] [R20]
						else if (cmd_q && data_q == CMD_A20_NULL) begin
							d1_pend_d = 1'b0; // [R18]
						end else if (!cmd_q && d1_pend_q) begin
							a20_d = data_q[A20_DATA_BIT]; // [R17]
							d1_pend_d = 1'b0;
						end else begin
							d1_pend_d = 1'b0; // [R19]
							idr_d[0] = data_q;
							ibf_d[0] = 1'b1; // [R18]
						end
					end else begin
						idr_d[ch_q] = data_q;
						ibf_d[ch_q] = 1'b1;
						if (ch_q == 2'd0)
							cd1_d = cmd_q;
					end
				end
				default: st_d = S_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= S_IDLE;
			cnt_q <= 3'd0;
			wr_q <= 1'b0;
			addr_q <= 16'h0000;
			data_q <= 8'h00;
			ch_q <= 2'd0;
			cmd_q <= 1'b0;
			lad_o_q <= 4'hF;
			lad_oe_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				idr_q[i] <= 8'h00;
				odr_q[i] <= 8'h00;
			end
			ibf_q <= 4'h0;
			obf_q <= 4'h0;
			cd1_q <= 1'b0;
			a20_q <= A20_RESET_VALUE; // [R15]
			d1_pend_q <= 1'b0;
			abort_q <= 1'b0;
			rdo_q <= 8'h00;
			busy_out <= 1'b0;
			port_active_out <= 1'b0;
			extra_pins_active_out <= 4'h0;
			addr_line20_mask_out <= A20_RESET_VALUE;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			addr_q <= addr_d;
			data_q <= data_d;
			ch_q <= ch_d;
			cmd_q <= cmd_d;
			lad_o_q <= lad_o_d;
			lad_oe_q <= lad_oe_d;
			idr_q <= idr_d;
			odr_q <= odr_d;
			ibf_q <= ibf_d;
			obf_q <= obf_d;
			cd1_q <= cd1_d;
			a20_q <= a20_d;
			d1_pend_q <= d1_pend_d;
			abort_q <= abort_d;
			rdo_q <= rdo_d;
			busy_out <= st_d inside {S_WDATA, S_TAR1, S_TAR2, S_SYNC, S_RDATA, S_RECOV}; // [R10]
			port_active_out <= |chan_enable_in; // [R01]
			extra_pins_active_out <= {sci_pin_enable_in, smi_pin_enable_in,
				power_event_pin_enable_in, fast_a20_enable_in}; // [R02]
			addr_line20_mask_out <= a20_d; // [R16]
		end
	end
	assign input_data_reg_out = rdo_q;
	assign input_buffer_full_out = ibf_q;
	assign chan1_cmd_or_data_flag_out = cd1_q;
	assign abort_flag_out = abort_q;
	assign lpc.lad_dev = lad_o_q;
	assign lpc.lad_dev_oe = lad_oe_q & port_active_out;
	assign lpc.a20_pin = a20_q;
	assign lpc.a20_pin_oe = extra_pins_active_out[0]; // [R14]
endmodule : lpc_dev
`default_nettype wire

// >>> logic/lpc_host.sv
`timescale 1ns/100ps
`default_nettype none
module lpc_host (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	lpc_if.host lpc,
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out
);
	import lpc_pkg::*;
	typedef enum {H_IDLE, H_START, H_TYPE, H_ADDR, H_WDATA, H_RECOV, H_TAR, H_SYNC, H_RDATA, H_END} hst_t;
	hst_t st_q, st_d;
	logic [2:0] div_q, div_d;
	logic lclk_q, lclk_d;
	logic [2:0] cnt_q, cnt_d;
	logic [15:0] addr_q, addr_d;
	logic [7:0] wdat_q, wdat_d, rdat_q, rdat_d;
	logic wr_q, wr_d, go_q, go_d, abort_flag_q, abort_flag_d, busy_q, busy_d;
	logic frame_q, frame_d, oe_q, oe_d;
	logic [3:0] lad_q, lad_d;
	logic [15:0] rdo_q, rdo_d;
	logic fall;
	assign fall = lclk_q && div_q == 3'(CLK_DIV_HALF - 1);
	always_comb begin
		st_d = st_q;
		div_d = div_q + 3'd1;
		lclk_d = lclk_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		wdat_d = wdat_q;
		rdat_d = rdat_q;
		wr_d = wr_q;
		go_d = go_q;
		abort_flag_d = abort_flag_q;
		busy_d = busy_q;
		frame_d = frame_q;
		oe_d = oe_q;
		lad_d = lad_q;
		rdo_d = rdo_q;
		if (div_q == 3'(CLK_DIV_HALF - 1)) begin
			div_d = 3'd0;
			lclk_d = ~lclk_q;
		end
		if (wr_in) begin
			if (addr_in == HREG_ADDR)
				addr_d = wdata_in;
			else if (addr_in == HREG_WDATA)
				wdat_d = wdata_in[7:0];
			else if (addr_in == HREG_CTRL) begin
				go_d = wdata_in[CTRL_GO_BIT] | go_q;
				wr_d = wdata_in[CTRL_WRITE_BIT];
				abort_flag_d = wdata_in[CTRL_ABORT_BIT];
			end
		end
		if (rd_in) begin
			if (addr_in == HREG_STATUS)
				rdo_d = {14'h0000, go_q, busy_q};
			else if (addr_in == HREG_RDATA)
				rdo_d = {8'h00, rdat_q};
			else
				rdo_d = 16'h0000;
		end
		// Drive on the falling link edge so the device samples stable data
		if (fall) begin
			if (abort_flag_q && busy_q) begin
				st_d = H_END; // [R07]
				frame_d = 1'b0;
				oe_d = 1'b1;
				lad_d = LAD_RECOVERY;
				abort_flag_d = 1'b0;
			end else
			case (st_q)
				H_IDLE: if (go_q) begin
					go_d = 1'b0;
					busy_d = 1'b1;
					st_d = H_TYPE;
					frame_d = 1'b0;
					oe_d = 1'b1;
					lad_d = LAD_START;
				end
				H_TYPE: begin
					frame_d = 1'b1;
					lad_d = wr_q ? LAD_TYPE_IO_WR : LAD_TYPE_IO_RD; // [R12] [R13]
					cnt_d = 3'd0;
					st_d = H_ADDR;
				end
				H_ADDR: begin
					lad_d = addr_q[15 - 4 * cnt_q -: 4]; // [R08]
					cnt_d = cnt_q + 3'd1;
					if (cnt_q == 3'd3) begin
						cnt_d = 3'd0;
						st_d = wr_q ? H_WDATA : H_RECOV;
					end
				end
				H_WDATA: begin
					lad_d = cnt_q == 3'd0 ? wdat_q[3:0] : wdat_q[7:4];
					cnt_d = cnt_q + 3'd1;
					if (cnt_q == 3'd1)
						st_d = H_RECOV;
				end
				H_RECOV: begin
					lad_d = LAD_RECOVERY;
					st_d = H_TAR;
				end
				H_TAR: begin
					oe_d = 1'b0;
					cnt_d = 3'd0;
					st_d = H_SYNC;
				end
				H_SYNC: begin
					cnt_d = cnt_q + 3'd1;
					if (lpc.lad == LAD_SYNC_READY) begin
						cnt_d = 3'd0;
						st_d = wr_q ? H_END : H_RDATA;
					end else if (cnt_q == 3'(SYNC_TIMEOUT - 1)) begin
						// Nobody claimed the cycle: abort it so the host never hangs
						st_d = H_END;
						frame_d = 1'b0;
						oe_d = 1'b1;
						lad_d = LAD_RECOVERY;
					end
				end
				H_RDATA: begin
					rdat_d = {lpc.lad, rdat_q[7:4]};
					cnt_d = cnt_q + 3'd1;
					if (cnt_q == 3'd1)
						st_d = H_END;
				end
				H_END: begin
					frame_d = 1'b1;
					oe_d = 1'b0;
					busy_d = 1'b0;
					st_d = H_IDLE;
				end
				default: st_d = H_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= H_IDLE;
			div_q <= 3'd0;
			lclk_q <= 1'b0;
			cnt_q <= 3'd0;
			addr_q <= 16'h0000;
			wdat_q <= 8'h00;
			rdat_q <= 8'h00;
			wr_q <= 1'b0;
			go_q <= 1'b0;
			abort_flag_q <= 1'b0;
			busy_q <= 1'b0;
			frame_q <= 1'b1;
			oe_q <= 1'b0;
			lad_q <= 4'hF;
			rdo_q <= 16'h0000;
		end else begin
			st_q <= st_d;
			div_q <= div_d;
			lclk_q <= lclk_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			wr_q <= wr_d;
			go_q <= go_d;
			abort_flag_q <= abort_flag_d;
			busy_q <= busy_d;
			frame_q <= frame_d;
			oe_q <= oe_d;
			lad_q <= lad_d;
			rdo_q <= rdo_d;
		end
	end
	assign lpc.lclk = lclk_q;
	assign lpc.lframe_n = frame_q;
	assign lpc.lad_host = lad_q;
	assign lpc.lad_host_oe = oe_q;
	assign rdata_out = rdo_q;
endmodule : lpc_host
`default_nettype wire
